// ### design/aurt_pkg.sv
package aurt_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CLKCTL  = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO  = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI  = 8'h0c;
    localparam logic [7:0] ADDR_RLD_LO  = 8'h10;
    localparam logic [7:0] ADDR_RLD_HI  = 8'h14;
    localparam logic [7:0] ADDR_GIE     = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1c;
    localparam logic [7:0] ADDR_CLEAR   = 8'h20;
    localparam logic [7:0] ADDR_ENABLE  = 8'h24;
    // control, clock select, gie and status/enable register fields
    localparam int CTRL_HI_OVF  = 7;
    localparam int CTRL_LO_OVF  = 6;
    localparam int CTRL_LO_IEN  = 5;
    localparam int CTRL_SPLIT   = 3;
    localparam int CTRL_RUN     = 2;
    localparam int CTRL_EXTSEL  = 0;
    localparam int CLK_LO_SEL   = 0;
    localparam int CLK_HI_SEL   = 1;
    localparam int GIE_TIMER    = 5;
    localparam int ST_HI        = 0;
    localparam int ST_LO        = 1;
    // reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [1:0] IRQ_RST    = 2'h0;
    // clock dividers and bus responses
    localparam int SYS_DIV      = 12;
    localparam int EXT_DIV      = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/aurt_cnt_if.sv
`timescale 1ns/1ps
interface aurt_cnt_if;
    logic       tick;
    logic       reload_now;
    logic [7:0] reload_val;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] count;
    logic       carry;
    modport ctrl  (output tick, output reload_now, output reload_val, output wr, output wdata,
                   input count, input carry);
    modport timer (input tick, input reload_now, input reload_val, input wr, input wdata,
                   output count, output carry);
endinterface

// ### design/aurt_byte_timer.sv
`timescale 1ns/1ps
module aurt_byte_timer
    import aurt_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // counter port
    aurt_cnt_if.timer cp
);
    // rolls over on a tick while at all ones
    assign cp.carry = cp.tick && (cp.count == 8'hff);

    // bus write wins over counting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cp.count <= BYTE_RST;
        end else if (cp.wr) begin
            cp.count <= cp.wdata;
        end else if (cp.carry) begin
            cp.count <= cp.reload_now ? cp.reload_val : 8'h00;
        end else if (cp.tick) begin
            cp.count <= cp.count + 8'h01;
        end
    end
endmodule

// ### design/aurt_timer.sv
`timescale 1ns/1ps
// Contract
// - count built from low and high bytes
// - sources: system clock, /12, external /8
// - external /8 tick synchronised to system clock
// - 16-bit rollover loads both reload bytes
// - 16-bit rollover sets high overflow flag
// - timer irq enable requests on overflow; here it also needs int_en[ST_HI]
// - low rollover irq needs low enable too
// - split mode: two 8-bit auto-reload timers
// - split: run gates high only, low free
// - per-byte select: system or external/div12; the high byte's select acts only in split mode
module aurt_timer
    import aurt_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // external oscillator, synchronous sampling
    input  wire logic        ext_osc,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // axi4-lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // interrupt
    output logic             irq
);
    logic [7:0] ctrl;
    logic [1:0] clkctl;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [7:0] gie;
    logic [1:0] status;
    logic [1:0] int_en;
    logic [3:0] div12;
    logic [2:0] div8;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_s3;
    logic       aw_full;
    logic       w_full;
    logic [7:0] aw_q;
    logic [7:0] w_q;
    logic       w_strb_q;

    aurt_cnt_if lo_if ();
    aurt_cnt_if hi_if ();

    // the two byte counters
    aurt_byte_timer u_lo (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cp      (lo_if.timer)
    );
    aurt_byte_timer u_hi (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cp      (hi_if.timer)
    );

    // mode and clock decode
    wire split    = ctrl[CTRL_SPLIT];
    wire run      = ctrl[CTRL_RUN];
    wire ext_sel  = ctrl[CTRL_EXTSEL];
    wire tick12   = (div12 == 4'(SYS_DIV - 1));
    wire ext_edge = ext_s2 && !ext_s3;
    wire tick_ext = ext_edge && (div8 == 3'(EXT_DIV - 1));
    wire slow     = ext_sel ? tick_ext : tick12;
    wire lo_src   = clkctl[CLK_LO_SEL] ? 1'b1 : slow;
    wire hi_src   = clkctl[CLK_HI_SEL] ? 1'b1 : slow;

    // system clock divided by twelve
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div12 <= 4'h0;
        end else begin
            div12 <= tick12 ? 4'h0 : div12 + 4'h1;
        end
    end

    // external oscillator synchroniser and divide by eight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            div8   <= 3'h0;
        end else begin
            ext_s1 <= ext_osc;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_edge) begin
                div8 <= div8 + 3'h1;
            end
        end
    end

    // write channel acceptance, either order
    wire aw_hs  = awvalid && awready;
    wire w_hs   = wvalid && wready;
    wire do_wr  = (aw_full || aw_hs) && (w_full || w_hs);
    wire [7:0] wa  = aw_full ? aw_q : awaddr;
    wire [7:0] wd  = w_full ? w_q : wdata[7:0];
    wire       wst = w_full ? w_strb_q : wstrb[0];
    wire       wen = do_wr && wst;
    wire wr_ctrl   = wen && (wa == ADDR_CTRL);
    wire wr_clkctl = wen && (wa == ADDR_CLKCTL);
    wire wr_cnt_lo = wen && (wa == ADDR_CNT_LO);
    wire wr_cnt_hi = wen && (wa == ADDR_CNT_HI);
    wire wr_rld_lo = wen && (wa == ADDR_RLD_LO);
    wire wr_rld_hi = wen && (wa == ADDR_RLD_HI);
    wire wr_gie    = wen && (wa == ADDR_GIE);
    wire wr_clear  = wen && (wa == ADDR_CLEAR);
    wire wr_enable = wen && (wa == ADDR_ENABLE);
    wire wa_hit    = (wa <= ADDR_ENABLE) && (wa[1:0] == 2'b00) && (wa != ADDR_STATUS);
    assign awready = !aw_full && !bvalid;
    assign wready  = !w_full && !bvalid;

    // counter steering
    assign lo_if.tick       = split ? lo_src : (lo_src && run);
    assign lo_if.reload_now = split ? 1'b1 : (hi_if.count == 8'hff);
    assign lo_if.reload_val = rld_lo;
    assign lo_if.wr         = wr_cnt_lo;
    assign lo_if.wdata      = wd;
    assign hi_if.tick       = split ? (hi_src && run) : lo_if.carry;
    assign hi_if.reload_now = 1'b1;
    assign hi_if.reload_val = rld_hi;
    assign hi_if.wr         = wr_cnt_hi;
    assign hi_if.wdata      = wd;
    wire ev_hi = hi_if.carry;
    wire ev_lo = lo_if.carry;

    // write holding and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full  <= 1'b0;
            w_full   <= 1'b0;
            aw_q     <= 8'h00;
            w_q      <= 8'h00;
            w_strb_q <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            if (do_wr) begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wa_hit ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_full <= 1'b1;
                    aw_q    <= awaddr;
                end
                if (w_hs) begin
                    w_full   <= 1'b1;
                    w_q      <= wdata[7:0];
                    w_strb_q <= wstrb[0];
                end
                if (bvalid && bready) begin
                    bvalid <= 1'b0;
                end
            end
        end
    end

    // software registers, hardware set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl   <= CTRL_RST;
            clkctl <= 2'h0;
            rld_lo <= BYTE_RST;
            rld_hi <= BYTE_RST;
            gie    <= 8'h00;
            int_en <= IRQ_RST;
            status <= IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wd & 8'hed;
            end
            if (ev_hi) begin
                ctrl[CTRL_HI_OVF] <= 1'b1;
            end
            if (ev_lo && split) begin
                ctrl[CTRL_LO_OVF] <= 1'b1;
            end
            if (wr_clkctl) begin
                clkctl <= wd[1:0];
            end
            if (wr_rld_lo) begin
                rld_lo <= wd;
            end
            if (wr_rld_hi) begin
                rld_hi <= wd;
            end
            if (wr_gie) begin
                gie <= wd;
            end
            if (wr_enable) begin
                int_en <= wd[1:0];
            end
            status <= (status & ~(wr_clear ? wd[1:0] : 2'h0)) | {ev_lo, ev_hi};
        end
    end

    // interrupt: high overflow needs its int_en bit, low rollover needs its int_en bit and the control enable
    wire gie_on = gie[GIE_TIMER];
    wire hi_req = status[ST_HI] && int_en[ST_HI];
    wire lo_req = status[ST_LO] && int_en[ST_LO] && ctrl[CTRL_LO_IEN];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= gie_on && (hi_req || lo_req);
        end
    end

    // read channel
    logic [7:0] rd_mux;
    logic       rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            ADDR_CTRL:   rd_mux = ctrl;
            ADDR_CLKCTL: rd_mux = {6'h00, clkctl};
            ADDR_CNT_LO: rd_mux = lo_if.count;
            ADDR_CNT_HI: rd_mux = hi_if.count;
            ADDR_RLD_LO: rd_mux = rld_lo;
            ADDR_RLD_HI: rd_mux = rld_hi;
            ADDR_GIE:    rd_mux = gie;
            ADDR_STATUS: rd_mux = {6'h00, status};
            ADDR_CLEAR:  rd_mux = 8'h00;
            ADDR_ENABLE: rd_mux = {6'h00, int_en};
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_mux};
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // divider, synchroniser and source select checks
    a_div12_period: assert property (tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12
        ##1 !tick12 ##1 tick12)
        else $error("div12 period wrong");
    a_ext_spacing: assert property (tick_ext |=> !tick_ext [*8])
        else $error("external tick too close");
    a_lo_div12: assert property (split && !clkctl[CLK_LO_SEL] && !ext_sel && !tick12
        |-> !lo_if.tick)
        else $error("low timer off the div12 tick");
    a_lo_ext: assert property (split && !clkctl[CLK_LO_SEL] && ext_sel && !tick_ext
        |-> !lo_if.tick)
        else $error("low timer off the external tick");

    // counter checks
    a_reload_16: assert property (!split && hi_if.carry
        && !lo_if.wr && !hi_if.wr
        |=> {hi_if.count, lo_if.count} == {$past(rld_hi), $past(rld_lo)})
        else $error("16-bit reload wrong");
    a_run_hold: assert property (!split && !run && !lo_if.wr && !hi_if.wr
        |=> $stable({hi_if.count, lo_if.count}))
        else $error("counter moved");
    a_reload_lo8: assert property (split && lo_if.carry && !lo_if.wr
        |=> lo_if.count == $past(rld_lo))
        else $error("8-bit reload wrong");
    a_reload_hi8: assert property (split && hi_if.carry && !hi_if.wr
        |=> hi_if.count == $past(rld_hi))
        else $error("high 8-bit reload wrong");
    a_lo_free: assert property (split && lo_src |-> lo_if.tick)
        else $error("low timer gated");
    a_lo_step: assert property (split && clkctl[CLK_LO_SEL] && !lo_if.wr
        && lo_if.count != 8'hff |=> lo_if.count == $past(lo_if.count) + 8'h01)
        else $error("low timer did not step");
    a_hi_stopped: assert property (split && !run && !hi_if.wr
        |=> $stable(hi_if.count)) else $error("high timer ran while stopped");
    a_hi_sys: assert property (split && run && clkctl[CLK_HI_SEL] |-> hi_if.tick)
        else $error("high select wrong");

    // flag and interrupt checks
    a_hi_flag: assert property (ev_hi && !wr_ctrl |=> ctrl[CTRL_HI_OVF])
        else $error("high flag not set");
    a_lo_flag: assert property (split && ev_lo && !wr_ctrl |=> ctrl[CTRL_LO_OVF])
        else $error("low flag not set");
    a_status_hi: assert property (ev_hi |=> status[ST_HI])
        else $error("high status not set");
    a_status_lo: assert property (ev_lo |=> status[ST_LO])
        else $error("low status not set");
    a_irq_ovf: assert property (gie_on && int_en[ST_HI] && ev_hi && !wr_gie
        && !wr_enable |=> ##1 irq)
        else $error("overflow irq missing");
    a_irq_lo_gate: assert property (irq |-> $past(gie_on))
        else $error("irq not gated");
    a_irq_lo_need: assert property (irq && !$past(hi_req)
        |-> $past(ctrl[CTRL_LO_IEN]) && $past(status[ST_LO]) && $past(int_en[ST_LO]))
        else $error("low irq without its enable");

    // bus checks
    a_bad_addr: assert property (do_wr && !wa_hit |=> bvalid && bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_ctrl_spare: assert property (!ctrl[1] && !ctrl[4])
        else $error("spare control bit set");
    a_wr_answer: assert property (do_wr |=> bvalid)
        else $error("write response missing");
    a_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data missing");

    // main scenarios
    c_roll16: cover property (!split && hi_if.carry);
    c_split_both: cover property (split && lo_if.carry ##[1:600] hi_if.carry);
    c_irq: cover property (!irq ##1 irq);
    c_ext: cover property (tick_ext && lo_if.tick);
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    import aurt_pkg::*;
    // clock, reset and design pins
    logic        aclk;
    logic        aresetn;
    logic        ext_osc;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        irq;
    // bookkeeping
    int          failures;
    int          num_checks;
    integer      seed;
    logic [31:0] d;
    logic [31:0] h;
    logic [1:0]  r;
    logic [15:0] rl;
    // irq walk: register, value, expected irq
    logic [7:0]  ta [7] = '{ADDR_GIE, ADDR_ENABLE, ADDR_CTRL, ADDR_GIE, ADDR_CLEAR, ADDR_CTRL,
                            ADDR_ENABLE};
    logic [7:0]  tv [7] = '{8'h00, 8'h03, 8'h20, 8'h20, 8'h01, 8'h00, 8'h01};
    logic        ti [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    // clock source walk: low select system, external select
    logic        cs [3] = '{1'b1, 1'b0, 1'b0};
    logic        cx [3] = '{1'b0, 1'b0, 1'b1};

    aurt_timer dut (
        .aclk, .aresetn, .ext_osc, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .irq
    );

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // external oscillator at half the system rate
    always @(posedge aclk) begin
        ext_osc <= ~ext_osc;
    end

    // expected ticks of the low byte over a span
    function automatic logic [7:0] ticks(input int cyc, input logic sys, input logic ext);
        return sys ? 8'(cyc) : (ext ? 8'(cyc / (2 * EXT_DIV)) : 8'(cyc / SYS_DIV));
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // axi4-lite write, aw and w offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    // axi4-lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // write expecting okay
    task automatic wo(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask

    // read expecting okay and a value
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
        chk(d, exp);
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        finish_test;
    end

    // main sequence
    initial begin
        seed = 81;
        failures = 0;
        num_checks = 0;
        {aresetn, ext_osc, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values and refused accesses
        rc(ADDR_CTRL, 32'(CTRL_RST));
        rc(ADDR_CNT_LO, 32'(BYTE_RST));
        rc(ADDR_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        rd(8'h28, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(ADDR_STATUS, 32'h3, r);
        chk(32'(r), 32'(RESP_SLVERR));
        endt("reset");
        // 16-bit hold while stopped
        wo(ADDR_CLKCTL, 32'h3);
        wo(ADDR_CNT_LO, 32'h34);
        wo(ADDR_CNT_HI, 32'h12);
        repeat (20) @(posedge aclk);
        rc(ADDR_CNT_LO, 32'h34);
        rc(ADDR_CNT_HI, 32'h12);
        endt("hold");
        // 16-bit rollover with random reload
        for (int i = 0; i < 4; i++) begin
            rl = 16'hffc0 | 16'($random(seed) & 32'h3f);
            wo(ADDR_CLEAR, 32'h3);
            wo(ADDR_CTRL, 32'h0);
            wo(ADDR_RLD_LO, 32'(rl[7:0]));
            wo(ADDR_RLD_HI, 32'(rl[15:8]));
            wo(ADDR_CNT_LO, 32'hf0);
            wo(ADDR_CNT_HI, 32'hff);
            wo(ADDR_CTRL, 32'h04);
            repeat (300) @(posedge aclk);
            rd(ADDR_CTRL, d, r);
            chk(d & 32'hcc, 32'h84);
            rc(ADDR_STATUS, 32'h3);
            wo(ADDR_CTRL, 32'h0);
            rd(ADDR_CNT_LO, d, r);
            rd(ADDR_CNT_HI, h, r);
            chk(32'({h[7:0], d[7:0]} >= rl), 32'h1);
        end
        endt("rollover");
        // interrupt enables, masking and clearing
        for (int i = 0; i < 7; i++) begin
            wo(ta[i], 32'(tv[i]));
            repeat (2) @(posedge aclk);
            chk(32'(irq), 32'(ti[i]));
        end
        wo(ADDR_GIE, 32'h0);
        endt("irq");
        // split mode, high stopped then running
        wo(ADDR_CLEAR, 32'h3);
        wo(ADDR_RLD_LO, 32'hf0);
        wo(ADDR_RLD_HI, 32'h55);
        wo(ADDR_CNT_LO, 32'hf0);
        wo(ADDR_CNT_HI, 32'ha7);
        wo(ADDR_CTRL, 32'h08);
        repeat (100) @(posedge aclk);
        rc(ADDR_CNT_HI, 32'ha7);
        rd(ADDR_CNT_LO, d, r);
        chk(32'(d[7:0] >= 8'hf0), 32'h1);
        rd(ADDR_CTRL, d, r);
        chk(d & 32'hc0, 32'h40);
        rc(ADDR_STATUS, 32'h2);
        wo(ADDR_CNT_HI, 32'hfe);
        wo(ADDR_CTRL, 32'h4c);
        repeat (100) @(posedge aclk);
        rd(ADDR_CNT_HI, d, r);
        chk(32'(d[7:0] >= 8'h55), 32'h1);
        rd(ADDR_CTRL, d, r);
        chk(d & 32'hc0, 32'hc0);
        endt("split");
        // clock sources of the free-running low byte
        wo(ADDR_RLD_LO, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wo(ADDR_CTRL, 32'h08 | 32'(cx[i]));
            wo(ADDR_CLKCTL, 32'(cs[i]));
            wo(ADDR_CNT_LO, 32'h0);
            repeat (160) @(posedge aclk);
            rd(ADDR_CNT_LO, d, r);
            chk(32'(8'(d[7:0] - ticks(160, cs[i], cx[i]) + 8'd2) <= 8'd6), 32'h1);
        end
        endt("clocks");
        finish_test;
    end
endmodule
